/* File: test/cnt_clk_src.sv */
// peripheral clock source standing in for the counter side
`timescale 1ns/1ps
`default_nettype none

module cnt_clk_src #(
  parameter int HALF = 4 // bus cycles per phase, 2 or more
) (
  input wire logic mclk_i,
  input wire logic run_i,
  output logic cnt_clk_o
);
  int ticks = 0; // cycles spent in the current phase
  initial cnt_clk_o = 1'b0;

  // finish a high phase before parking low, so no runt pulse
  always @(posedge mclk_i)
  begin
    if (run_i || cnt_clk_o)
    begin
      ticks <= (ticks == HALF - 1) ? 0 : ticks + 1;
      if (ticks == HALF - 1)
        cnt_clk_o <= !cnt_clk_o;
    end
    else
      ticks <= 0;
  end
endmodule
`default_nettype wire

/* File: test/coherent_counter_cdc_properties.sv */
// assertion checker bound onto the coherent counter crossing
`timescale 1ns/1ps
`default_nettype none
`include "coherent_counter_map.svh"

module coherent_counter_cdc_properties
  import coherent_counter_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire clk_rel_t clk_rel_i,
  input wire logic cnt_clk_i,
  input wire wr_req_t wr_i,
  input wire rd_req_t rd_i,
  input wire logic [`CC_BUS_W-1:0] rd_data_o,
  input wire logic [`CC_CNT_W-1:0] count_o,
  input wire logic counter_load_pulse_o,
  input wire logic fresh_write_flag_o,
  input wire logic retimed_fresh_flag_o
);
  logic [1:0] settle_q, settle_d; // edges seen since reset release
  logic [23:0] shadow_q, shadow_d; // lower bytes as written
  logic [31:0] commit_q, commit_d; // last committed reload value
  logic [23:0] hold_q, hold_d; // upper bytes at last byte 0 read
  logic ok; // strap decode settled, requests allowed
  logic loc; // identical or synchronous relation
  assign ok = settle_q == 2'h3;
  assign loc = ok && clk_rel_i != REL_ASYNC;

  // next reference state; async read source is hidden, so skip it
  always_comb
  begin
    settle_d = ok ? settle_q : settle_q + 2'h1;
    shadow_d = shadow_q;
    commit_d = commit_q;
    hold_d = hold_q;
    if (wr_i.en && wr_i.sel != `CC_UPPER_BYTE)
      shadow_d[8*wr_i.sel +: 8] = wr_i.data;
    if (wr_i.en && wr_i.sel == `CC_UPPER_BYTE)
      commit_d = {wr_i.data, shadow_q};
    if (loc && rd_i.en && rd_i.sel == `CC_LOWER_BYTE)
      hold_d = count_o[31:8];
  end

  // register reference state
  always_ff @(posedge mclk_i)
  begin
    settle_q <= rst_n_i ? settle_d : 2'h0;
    shadow_q <= rst_n_i ? shadow_d : 24'h0;
    commit_q <= rst_n_i ? commit_d : 32'h0;
    hold_q <= rst_n_i ? hold_d : 24'h0;
  end

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  AST_IDENT_PULSE: assert property (ok && clk_rel_i == REL_IDENT &&
    wr_i.en && wr_i.sel == `CC_UPPER_BYTE |=> counter_load_pulse_o
    ##1 !counter_load_pulse_o) else $error("load pulse not one cycle");
  AST_IDENT_COUNT: assert property (ok && clk_rel_i == REL_IDENT &&
    !counter_load_pulse_o |=> count_o == $past(count_o) - 32'h1)
    else $error("counter did not step");
  AST_SYNC_HOLD: assert property ((ok && clk_rel_i == REL_SYNC &&
    !cnt_clk_i)[*7] ##0 counter_load_pulse_o |=> counter_load_pulse_o)
    else $error("load pulse dropped without a tick");
  AST_SYNC_CLEAR: assert property (ok && clk_rel_i == REL_SYNC &&
    counter_load_pulse_o && $rose(cnt_clk_i) |-> ##[1:8]
    !counter_load_pulse_o) else $error("load pulse not cleared");
  AST_LOADED: assert property (ok && ($fell(counter_load_pulse_o) ||
    $fell(fresh_write_flag_o)) |-> count_o == commit_q)
    else $error("counter not loaded with committed value");
  AST_SAFE_COPY: assert property ($rose(retimed_fresh_flag_o) |->
    $past(fresh_write_flag_o)) else $error("safe flag without fresh");
  AST_ASYNC_BOUND: assert property (ok && clk_rel_i == REL_ASYNC &&
    $rose(fresh_write_flag_o) |-> ##[1:40] !fresh_write_flag_o)
    else $error("async load took too long");
  AST_FLAG_PAIR: assert property ($fell(fresh_write_flag_o) |->
    ##[0:2] !retimed_fresh_flag_o) else $error("safe flag left set");
  AST_RD_LOW: assert property (loc && rd_i.en &&
    rd_i.sel == `CC_LOWER_BYTE |=> rd_data_o == $past(count_o[7:0]))
    else $error("low byte not live count");
  AST_RD_UPPER: assert property (loc && rd_i.en &&
    rd_i.sel != `CC_LOWER_BYTE |=> rd_data_o ==
    8'(hold_q >> (8 * $past(rd_i.sel) - 8)))
    else $error("upper byte not from holding");
endmodule

bind coherent_counter_cdc coherent_counter_cdc_properties u_props (
  .mclk_i, .rst_n_i, .clk_rel_i, .cnt_clk_i, .wr_i, .rd_i, .rd_data_o,
  .count_o, .counter_load_pulse_o, .fresh_write_flag_o,
  .retimed_fresh_flag_o
);
`default_nettype wire

/* File: test/coherent_counter_cdc_tb.sv */
// self-checking bench for the coherent counter crossing
`timescale 1ns/1ps
`default_nettype none
`include "coherent_counter_map.svh"

module coherent_counter_cdc_tb;
  import coherent_counter_pkg::*;
  logic mclk_i;
  logic rst_n_i;
  clk_rel_t clk_rel_i;
  logic cnt_clk; // peripheral clock from the source model
  logic run; // lets the peripheral clock run
  wr_req_t wr_i;
  rd_req_t rd_i;
  logic [7:0] rd_data_o;
  logic [31:0] count_o;
  logic pulse;
  logic fresh;
  logic safe;
  int error_cnt;
  int check_count;

  coherent_counter_cdc u_coherent_counter_cdc (.mclk_i(mclk_i),
    .rst_n_i(rst_n_i), .clk_rel_i(clk_rel_i), .cnt_clk_i(cnt_clk),
    .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .count_o(count_o),
    .counter_load_pulse_o(pulse), .fresh_write_flag_o(fresh),
    .retimed_fresh_flag_o(safe));
  cnt_clk_src #(.HALF(4)) u_cnt_clk_src (.mclk_i(mclk_i), .run_i(run),
    .cnt_clk_o(cnt_clk));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected value at %0t: %h not %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // strap changes only under reset; requests wait past the decode lag
  task automatic reset_to(input clk_rel_t m);
    @(posedge mclk_i);
    rst_n_i <= 1'b0;
    clk_rel_i <= m;
    repeat (5) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
  endtask

  // bytes back to back, enable held between them
  task automatic wr_bytes(input int first, input int last,
    input logic [31:0] v);
    for (int k = first; k <= last; k++)
    begin
      @(posedge mclk_i);
      wr_i <= {1'b1, 2'(k), v[8*k +: 8]};
    end
    @(posedge mclk_i);
    wr_i.en <= 1'b0;
  endtask

  // bytes 0 to 3 in order, data sampled one cycle after each request
  task automatic rd_word(output logic [31:0] v);
    for (int k = 0; k <= 4; k++)
    begin
      @(posedge mclk_i);
      rd_i <= {k < 4, 2'(k)};
      #1;
      if (k > 0)
        v[8*k-8 +: 8] = rd_data_o;
    end
  endtask

  // bounded wait for the load pulse or the fresh flag to drop
  task automatic wait_clear(input bit use_fresh);
    int n;
    n = 0;
    #1;
    while ((use_fresh ? fresh : pulse) === 1'b1 && n < 60)
    begin
      @(posedge mclk_i);
      #1;
      n++;
    end
  endtask

  task automatic test_ident();
    logic [31:0] got;
    reset_to(REL_IDENT);
    wr_bytes(0, 3, 32'h1234_5678);
    #1;
    check(pulse, 32'h1);
    @(posedge mclk_i);
    #1;
    check(pulse, 32'h0);
    check(count_o, 32'h1234_5678);
    rd_word(got);
    check(got, 32'h1234_5677);
    wr_bytes(0, 2, 32'h00aa_bbcc);
    #1;
    check(pulse, 32'h0);
    wr_bytes(3, 3, 32'h9900_0000);
    @(posedge mclk_i);
    #1;
    check(count_o, 32'h99aa_bbcc);
  endtask

  task automatic test_sync();
    logic [31:0] got;
    reset_to(REL_SYNC);
    wr_bytes(0, 3, 32'hfedc_0201);
    // counter clock parked: the pulse must wait for a counter edge
    repeat (10) @(posedge mclk_i);
    run <= 1'b1;
    #1;
    check(pulse, 32'h1);
    check(count_o, 32'h0);
    wait_clear(1'b0);
    check(pulse, 32'h0);
    check(count_o, 32'hfedc_0201);
    @(posedge mclk_i);
    run <= 1'b0;
    rd_word(got);
    check(got, 32'hfedc_0201);
  endtask

  task automatic test_async();
    logic [31:0] got;
    reset_to(REL_ASYNC);
    run <= 1'b1;
    wr_bytes(0, 3, 32'h0bad_f00d);
    #1;
    check(fresh, 32'h1);
    wait_clear(1'b1);
    check(fresh, 32'h0);
    check(safe, 32'h0);
    check(count_o, 32'h0bad_f00d);
    // one more counter edge copies the loaded count into the read
    // shadow, then the clock parks so the shadow stays put
    repeat (6) @(posedge mclk_i);
    run <= 1'b0;
    repeat (8) @(posedge mclk_i);
    #1;
    check(count_o, 32'h0bad_f00c);
    rd_word(got);
    check(got, 32'h0bad_f00d);
  endtask

  // free-running bus clock
  initial
  begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  // watchdog well beyond the hundred or so cycles the tests need
  initial
  begin
    repeat (3000) @(posedge mclk_i);
    error_cnt++;
    print_verdict();
  end

  initial
  begin
    error_cnt = 0;
    check_count = 0;
    rst_n_i = 1'b0;
    clk_rel_i = REL_IDENT;
    run = 1'b0;
    wr_i = '0;
    rd_i = '0;
    test_ident();
    test_sync();
    test_async();
    print_verdict();
  end
endmodule
`default_nettype wire

/* File: verilog/coherent_counter_cdc.sv */
// coherent byte-wide load and read of a 32-bit counter across clock relations
`timescale 1ns/1ps
`default_nettype none

module coherent_counter_cdc
  import coherent_counter_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire clk_rel_t clk_rel_i,
  input wire logic cnt_clk_i,
  input wire wr_req_t wr_i,
  input wire rd_req_t rd_i,
  output logic [`CC_BUS_W-1:0] rd_data_o,
  output logic [`CC_CNT_W-1:0] count_o,
  output logic counter_load_pulse_o,
  output logic fresh_write_flag_o,
  output logic retimed_fresh_flag_o
);

  // a full-width bus or a one-byte counter needs no read capture
  localparam bit no_coherency_needed =
    (`CC_CNT_W <= `CC_BUS_W) || (`CC_BUS_W >= 32);

  // re-timed pins
  logic cnt_clk_s; // counter clock after two flops
  logic [2:0] rel_s; // clock relation strap after two flops
  logic is_ident;
  logic is_sync;
  logic is_async;
  logic cnt_rise; // rising edge of the re-timed counter clock
  logic cnt_tick; // one counter clock period has begun

  // write side state
  logic [`CC_CNT_W-`CC_BUS_W-1:0] wr_shadow_q; // bytes 0..2 in waiting
  logic [`CC_CNT_W-`CC_BUS_W-1:0] wr_shadow_d;
  logic [`CC_CNT_W-1:0] committed_reload_value_q;
  logic [`CC_CNT_W-1:0] committed_reload_value_d;
  logic counter_load_pulse_q;
  logic counter_load_pulse_d;
  logic load_toggle_q; // flips on counter edge while pulse high
  logic load_toggle_d;
  logic load_toggle_chg;
  logic commit; // upper byte written this cycle

  // asynchronous write transfer state
  logic fresh_write_flag_q;
  logic fresh_write_flag_d;
  logic retimed_fresh_flag_q;
  logic retimed_fresh_flag_d;
  logic [`CC_CNT_W-1:0] retimed_reload_value_q;
  logic [`CC_CNT_W-1:0] retimed_reload_value_d;
  logic fresh_toggle_q; // flips each time the counter takes the safe value
  logic fresh_toggle_d;
  logic fresh_toggle_chg;

  // counter and read side state
  logic [`CC_CNT_W-1:0] count_q;
  logic [`CC_CNT_W-1:0] count_d;
  logic [`CC_CNT_W-1:0] cnt_shadow_q; // async stable copy of the count
  logic [`CC_CNT_W-1:0] cnt_shadow_d;
  logic [`CC_CNT_W-`CC_BUS_W-1:0] read_holding_reg_q;
  logic [`CC_CNT_W-`CC_BUS_W-1:0] read_holding_reg_d;
  logic [`CC_BUS_W-1:0] rd_data_q;
  logic [`CC_BUS_W-1:0] rd_data_d;
  logic [`CC_CNT_W-1:0] rd_src; // live count or async shadow

  // counter clock and strap cross on two flops each
  sync_stage #(
    .WIDTH(4)
  ) u_pin_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .async_i({cnt_clk_i, clk_rel_i}),
    .sync_o({cnt_clk_s, rel_s})
  );

  // rising edge of the re-timed counter clock
  edge_watch u_cnt_edge (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .level_i(cnt_clk_s),
    .rise_o(cnt_rise),
    .change_o()
  );

  // change on the synchronous-mode load toggle
  edge_watch u_load_tgl (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .level_i(load_toggle_q),
    .rise_o(),
    .change_o(load_toggle_chg)
  );

  // change on the asynchronous fresh-value toggle
  edge_watch u_fresh_tgl (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .level_i(fresh_toggle_q),
    .rise_o(),
    .change_o(fresh_toggle_chg)
  );

  // decode of the re-timed strap; an illegal code falls back to async,
  // the mode that makes no assumption about the clocks
  always_comb
  begin
    is_ident = 1'b0;
    is_sync = 1'b0;
    is_async = 1'b0;
    unique case (rel_s)
      REL_IDENT: is_ident = 1'b1;
      REL_SYNC: is_sync = 1'b1;
      default: is_async = 1'b1;
    endcase
  end

  // identical clocks tick every cycle, the others on a detected edge
  assign cnt_tick = is_ident | cnt_rise;
  assign commit = wr_i.en && (wr_i.sel == `CC_UPPER_BYTE);

  // next values of the write side
  always_comb
  begin
    wr_shadow_d = wr_shadow_q;
    committed_reload_value_d = committed_reload_value_q;
    counter_load_pulse_d = counter_load_pulse_q;
    load_toggle_d = load_toggle_q;
    // lower bytes wait here so the old load value stays usable
    if (wr_i.en && !commit)
    begin
      wr_shadow_d[wr_i.sel*`CC_BUS_W +: `CC_BUS_W] = wr_i.data;
    end
    // upper byte joins the waiting bytes in one step
    if (commit)
    begin
      committed_reload_value_d = {wr_i.data, wr_shadow_q};
    end
    if (is_ident)
    begin
      // single cycle pulse following the commit
      counter_load_pulse_d = commit;
    end
    else if (is_sync)
    begin
      // flip on each counter edge seen while the pulse stands
      if (cnt_tick && counter_load_pulse_q)
      begin
        load_toggle_d = ~load_toggle_q;
      end
      // a seen toggle ends the stretched pulse; a new commit wins
      if (commit)
      begin
        counter_load_pulse_d = 1'b1;
      end
      else if (load_toggle_chg)
      begin
        counter_load_pulse_d = 1'b0;
      end
    end
    else
    begin
      // async mode uses the fresh flags instead
      counter_load_pulse_d = 1'b0;
    end
  end

  // register the write side
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      wr_shadow_q <= '0;
      committed_reload_value_q <= `CC_LOAD_RST;
      counter_load_pulse_q <= 1'b0;
      load_toggle_q <= 1'b0;
    end
    else
    begin
      wr_shadow_q <= wr_shadow_d;
      committed_reload_value_q <= committed_reload_value_d;
      counter_load_pulse_q <= counter_load_pulse_d;
      load_toggle_q <= load_toggle_d;
    end
  end

  // next values of the asynchronous transfer; only the re-timed clock
  // edge moves data, so the wide value never meets a metastable flop
  always_comb
  begin
    fresh_write_flag_d = fresh_write_flag_q;
    retimed_fresh_flag_d = retimed_fresh_flag_q;
    retimed_reload_value_d = retimed_reload_value_q;
    fresh_toggle_d = fresh_toggle_q;
    if (is_async)
    begin
      // safe copies taken only on a detected counter edge
      if (cnt_rise)
      begin
        retimed_fresh_flag_d = fresh_write_flag_q;
        retimed_reload_value_d = committed_reload_value_q;
      end
      // counter took the value: flip the toggle once
      if (cnt_rise && retimed_fresh_flag_q)
      begin
        fresh_toggle_d = ~fresh_toggle_q;
      end
      // toggle edge clears both flags
      if (fresh_toggle_chg)
      begin
        fresh_write_flag_d = 1'b0;
        retimed_fresh_flag_d = 1'b0;
      end
      // a write landing with the clear is kept
      if (commit)
      begin
        fresh_write_flag_d = 1'b1;
      end
    end
    else
    begin
      fresh_write_flag_d = 1'b0;
      retimed_fresh_flag_d = 1'b0;
    end
  end

  // register the asynchronous transfer
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      fresh_write_flag_q <= 1'b0;
      retimed_fresh_flag_q <= 1'b0;
      retimed_reload_value_q <= `CC_LOAD_RST;
      fresh_toggle_q <= 1'b0;
    end
    else
    begin
      fresh_write_flag_q <= fresh_write_flag_d;
      retimed_fresh_flag_q <= retimed_fresh_flag_d;
      retimed_reload_value_q <= retimed_reload_value_d;
      fresh_toggle_q <= fresh_toggle_d;
    end
  end

  // next count: load on a qualified edge, else count down each period;
  // async copies land one edge, loading the next, so two periods at most
  always_comb
  begin
    count_d = count_q;
    cnt_shadow_d = cnt_shadow_q;
    if (cnt_tick)
    begin
      if ((is_ident || is_sync) && counter_load_pulse_q)
      begin
        count_d = committed_reload_value_q;
      end
      else if (is_async && retimed_fresh_flag_q)
      begin
        count_d = retimed_reload_value_q;
      end
      else
      begin
        count_d = count_q - `CC_CNT_W'(1);
      end
    end
    // count is stable at the detected edge, so take a copy for reads
    if (is_async && cnt_rise)
    begin
      cnt_shadow_d = count_q;
    end
  end

  // register the counter and its read shadow
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      count_q <= `CC_CNT_RST;
      cnt_shadow_q <= `CC_CNT_RST;
    end
    else
    begin
      count_q <= count_d;
      cnt_shadow_q <= cnt_shadow_d;
    end
  end

  // async reads see the shadow, the others the live count
  assign rd_src = is_async ? cnt_shadow_q : count_q;

  // next read data and holding contents; reads out of order return a
  // mix of two counts, which is the price of the byte 0 trigger
  always_comb
  begin
    rd_data_d = rd_data_q;
    read_holding_reg_d = read_holding_reg_q;
    if (rd_i.en)
    begin
      if (no_coherency_needed)
      begin
        // whole value in one access, straight from the source
        rd_data_d = rd_src[rd_i.sel*`CC_BUS_W +: `CC_BUS_W];
      end
      else if (rd_i.sel == `CC_LOWER_BYTE)
      begin
        // byte 0 returns now and freezes the rest
        rd_data_d = rd_src[`CC_BUS_W-1:0];
        read_holding_reg_d = rd_src[`CC_CNT_W-1:`CC_BUS_W];
      end
      else
      begin
        // upper bytes from the frozen copy, never the live count
        rd_data_d = read_holding_reg_q[(rd_i.sel-`CC_SEL_W'(1))*`CC_BUS_W
                    +: `CC_BUS_W];
      end
    end
  end

  // register read data and holding contents
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      rd_data_q <= `CC_RD_RST;
      read_holding_reg_q <= '0;
    end
    else
    begin
      rd_data_q <= rd_data_d;
      read_holding_reg_q <= read_holding_reg_d;
    end
  end

  // all outputs come from flops
  assign rd_data_o = rd_data_q;
  assign count_o = count_q;
  assign counter_load_pulse_o = counter_load_pulse_q;
  assign fresh_write_flag_o = fresh_write_flag_q;
  assign retimed_fresh_flag_o = retimed_fresh_flag_q;

endmodule

`default_nettype wire

/* File: verilog/coherent_counter_map.svh */
// widths, byte positions and reset values for the coherent counter
`ifndef COHERENT_COUNTER_MAP_SVH
`define COHERENT_COUNTER_MAP_SVH

// widths of the bus data path and of the counter
`define CC_BUS_W 8
`define CC_CNT_W 32
`define CC_SEL_W 2

// byte that commits a write and byte that triggers a read capture
`define CC_UPPER_BYTE 2'h3
`define CC_LOWER_BYTE 2'h0

// reset values
`define CC_CNT_RST 32'h0000_0000
`define CC_LOAD_RST 32'h0000_0000
`define CC_RD_RST 8'h00

// depth of the pin re-timing chain
`define CC_SYNC_STAGES 2

`endif

/* File: verilog/coherent_counter_pkg.sv */
// types shared by the coherent counter crossing logic
`include "coherent_counter_map.svh"

package coherent_counter_pkg;

  // relationship between the bus clock and the counter clock
  typedef enum logic [2:0]
  {
    REL_IDENT = 3'b001,
    REL_SYNC = 3'b010,
    REL_ASYNC = 3'b100
  } clk_rel_t;

  // one byte write from the bus side
  typedef struct packed
  {
    logic en;
    logic [`CC_SEL_W-1:0] sel;
    logic [`CC_BUS_W-1:0] data;
  } wr_req_t;

  // one byte read from the bus side
  typedef struct packed
  {
    logic en;
    logic [`CC_SEL_W-1:0] sel;
  } rd_req_t;

endpackage

/* File: verilog/edge_watch.sv */
// single-bit edge detector: rising edge and any change
`timescale 1ns/1ps
`default_nettype none

module edge_watch (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic level_i,
  output logic rise_o,
  output logic change_o
);

  logic prev_q; // level seen one cycle ago
  logic prev_d;

  // next value: remember the current level
  always_comb
  begin
    prev_d = level_i;
  end

  // register the previous level
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      prev_q <= 1'b0;
    end
    else
    begin
      prev_q <= prev_d;
    end
  end

  // combinational so the event is seen in the cycle it happens
  assign rise_o = level_i & ~prev_q;
  assign change_o = level_i ^ prev_q;

endmodule

`default_nettype wire

/* File: verilog/sync_stage.sv */
// two flip-flop re-timing chain for pins from another clock domain
`timescale 1ns/1ps
`default_nettype none

module sync_stage #(
  parameter int WIDTH = 1
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q; // first stage, read only by the second
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q; // second stage, safe to use
  logic [WIDTH-1:0] sync_d;

  // next values: shift the pin through both stages
  always_comb
  begin
    meta_d = async_i;
    sync_d = meta_q;
  end

  // both stages on the rising edge of the destination clock
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;

endmodule

`default_nettype wire
